// ===== design/vt_pkg.sv
// Purpose: Shared constants for the video terminal bus port
// Assumes: One 25 MHz clock, bus strobes synchronous to it
// Notes:   Scan divide ratios are plain defaults
`default_nettype none
package vt_pkg;
	localparam int          ADDR_W         = 16;
	localparam int          DATA_W         = 8;
	localparam int          MEM_WORDS      = 1024;
	localparam int          MEM_AW         = 10;
	localparam int          BASE_W         = 6;
	localparam int          PORT_W         = 7;
	localparam int          HALF_K_BIT     = 9;
	localparam int          STATUS_IRQ_BIT = 0;
	localparam int          STATUS_STB_BIT = 7;
	localparam int          COL_W          = 6;
	localparam int          ROW_W          = 4;
	localparam logic [5:0]  COL_LAST       = 6'h3f;
	localparam logic [3:0]  ROW_LAST       = 4'hf;
	localparam int          NARROW_COLS    = 32;
	localparam int          DIV_W          = 4;
	localparam logic [3:0]  DIV_RATIO_NATIVE = 4'h3;
	localparam logic [3:0]  DIV_RATIO_OTHER  = 4'h4;
	localparam logic [7:0]  RESET_BYTE     = 8'h00;
endpackage : vt_pkg
`default_nettype wire

// ===== design/scan_divider.sv
// Purpose: Character-rate enable from the system clock
// Assumes: Ratio select is static while running
// Notes:   One-cycle tick every ratio cycles
`default_nettype none
module scan_divider
	import vt_pkg::*;
(
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic clock_divide_select,
	output logic      tick_q
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] last;

	assign last = (clock_divide_select ? DIV_RATIO_OTHER : DIV_RATIO_NATIVE) - 4'h1;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else if (cnt_q >= last) begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 4'h1;
			tick_q <= 1'b0;
		end
	end

	a_tick_spacing: assert property (@(posedge clk) disable iff (!nrst)
		tick_q && !clock_divide_select && $stable(clock_divide_select)
		|=> !tick_q ##1 !tick_q ##1 (tick_q || clock_divide_select))
		else $error("scan tick spacing wrong");
endmodule : scan_divider
`default_nettype wire

// ===== design/video_terminal_board.sv
// Purpose: Bus face of the video terminal: display memory, keyboard ports, scan
// Assumes: Bus strobes are one-cycle pulses synchronous to clk
// Notes:   Read data appears one cycle after the strobe
`default_nettype none
module video_terminal_board
	import vt_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic [vt_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic [vt_pkg::DATA_W-1:0] bus_wdata,
	input  wire logic                     mem_rd,
	input  wire logic                     mem_wr,
	input  wire logic                     io_rd,
	input  wire logic [vt_pkg::BASE_W-1:0] base_select,
	input  wire logic                     half_k_select,
	input  wire logic [vt_pkg::PORT_W-1:0] port_select,
	input  wire logic                     line_length_select,
	input  wire logic                     clock_divide_select,
	input  wire logic                     strobe_polarity_select,
	input  wire logic [vt_pkg::DATA_W-1:0] kbd_data,
	input  wire logic                     kbd_strobe,
	output logic [vt_pkg::DATA_W-1:0]      bus_rdata_q,
	output logic                          bus_drive_q,
	output logic                          irq_q,
	output logic [vt_pkg::DATA_W-1:0]      char_code_q,
	output logic                          char_blank_q,
	output logic [vt_pkg::COL_W-1:0]       col_q,
	output logic [vt_pkg::ROW_W-1:0]       row_q
);
	import vt_pkg::*;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic mem_hit(input logic [ADDR_W-1:0] a,
	                                 input logic [BASE_W-1:0] base,
	                                 input logic              half);
		mem_hit = (a[ADDR_W-1:MEM_AW] == base) && !(half && a[HALF_K_BIT]);
	endfunction : mem_hit

	logic [DATA_W-1:0] vram [MEM_WORDS];
	logic [DATA_W-1:0] kbd_q;
	logic              active_lvl;
	logic              prev_q;
	logic              key_edge;
	logic              data_rd;
	logic              stat_rd;
	logic              mrd_hit;
	logic              mwr_hit;
	logic              tick;

	assign data_rd  = io_rd && (bus_addr[7:1] == port_select) && !bus_addr[0];
	assign stat_rd  = io_rd && (bus_addr[7:1] == port_select) && bus_addr[0];
	assign mrd_hit  = mem_rd && mem_hit(bus_addr, base_select, half_k_select);
	assign mwr_hit  = mem_wr && mem_hit(bus_addr, base_select, half_k_select);
	// Levels and pulses both show up as one active-going edge
	assign active_lvl = kbd_strobe ^ strobe_polarity_select;
	assign key_edge   = active_lvl && !prev_q;

	// ----------------------------------------
	// Keyboard capture
	// ----------------------------------------
	// Resets as if already active, so a held key is not seen at power-up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= active_lvl;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			kbd_q <= RESET_BYTE;
		end else if (key_edge) begin
			kbd_q <= kbd_data;
		end
	end

	// Set wins so a key during the read is not lost
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else if (key_edge) begin
			irq_q <= 1'b1;
		end else if (data_rd) begin
			irq_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Bus reads and writes
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (mwr_hit) begin
			vram[bus_addr[MEM_AW-1:0]] <= bus_wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_rdata_q <= RESET_BYTE;
			bus_drive_q <= 1'b0;
		end else begin
			bus_drive_q <= mrd_hit || data_rd || stat_rd;
			if (mrd_hit) begin
				bus_rdata_q <= vram[bus_addr[MEM_AW-1:0]];
			end else if (data_rd) begin
				bus_rdata_q <= kbd_q;
			end else if (stat_rd) begin
				bus_rdata_q                 <= RESET_BYTE;
				bus_rdata_q[STATUS_IRQ_BIT] <= irq_q;
				bus_rdata_q[STATUS_STB_BIT] <= kbd_strobe;
			end else begin
				bus_rdata_q <= RESET_BYTE;
			end
		end
	end

	// ----------------------------------------
	// Scan timing
	// ----------------------------------------
	scan_divider u_div (
		.clk                 (clk),
		.nrst                (nrst),
		.clock_divide_select (clock_divide_select),
		.tick_q              (tick)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			col_q <= '0;
			row_q <= '0;
		end else if (tick) begin
			col_q <= col_q + 6'h1;
			if (col_q == COL_LAST) begin
				row_q <= row_q + 4'h1;
			end
		end
	end

	// Half-K boards fold the upper half onto the lower
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			char_code_q  <= RESET_BYTE;
			char_blank_q <= 1'b1;
		end else if (tick) begin
			char_code_q  <= vram[{row_q & {!half_k_select, 3'h7}, col_q}];
			char_blank_q <= line_length_select && (col_q >= 6'(NARROW_COLS));
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_irq_set: assert property (key_edge |=> irq_q ##1 (irq_q || $past(data_rd)))
		else $error("keypress did not set irq");
	a_irq_clear: assert property (data_rd && !key_edge |=> !irq_q)
		else $error("data read did not clear irq");
	a_latch_load: assert property ((kbd_strobe ^ strobe_polarity_select) && !prev_q
		|=> kbd_q == $past(kbd_data))
		else $error("latch missed keypress");
	a_latch_hold: assert property (!key_edge |=> $stable(kbd_q))
		else $error("latch changed without keypress");
	a_data_port: assert property (data_rd |=> bus_drive_q && bus_rdata_q == $past(kbd_q))
		else $error("data port read wrong");
	a_status_bits: assert property (stat_rd |=> bus_rdata_q[0] == $past(irq_q)
		&& bus_rdata_q[7] == $past(kbd_strobe) && bus_rdata_q[6:1] == 6'h00)
		else $error("status read wrong");
	a_mem_miss: assert property (mem_rd && !io_rd
		&& bus_addr[ADDR_W-1:MEM_AW] != base_select |=> !bus_drive_q)
		else $error("memory decoded off base");
	a_half_hole: assert property (mem_rd && !io_rd && half_k_select && bus_addr[HALF_K_BIT]
		|=> !bus_drive_q)
		else $error("half K decoded upper half");
	a_narrow_blank: assert property (tick && line_length_select && col_q[5]
		|=> char_blank_q)
		else $error("column past 32 not blanked");
	a_wide_show: assert property (tick && !line_length_select |=> !char_blank_q)
		else $error("64 column line blanked");
	// Overlapping requests: the keypress set wins over the data read clear
	a_irq_set_wins: assert property (key_edge && data_rd |=> irq_q)
		else $error("read in keypress cycle lost the irq");
	a_mem_read: assert property (mrd_hit |=> bus_drive_q)
		else $error("memory read not answered");
	a_idle_quiet: assert property (!(mrd_hit || data_rd || stat_rd)
		|=> !bus_drive_q && bus_rdata_q == RESET_BYTE)
		else $error("bus driven without a read");
	a_col_step: assert property (tick |=> col_q == $past(col_q) + 6'h1)
		else $error("scan column did not advance");
	a_row_step: assert property (tick && col_q == COL_LAST
		|=> row_q == $past(row_q) + 4'h1)
		else $error("scan row did not advance");
	a_scan_hold: assert property (!tick |=> $stable(col_q) && $stable(row_q))
		else $error("scan moved without a tick");
endmodule : video_terminal_board
`default_nettype wire

// ===== verif/kbd_model.sv
// Purpose: Parallel keyboard stand-in driving eight data lines and a strobe
// Assumes: Calls are made just after a rising clk edge
// Notes:   Released data lines show the inverse of the last byte
`default_nettype none
module kbd_model (
	input  wire logic       clk,
	input  wire logic       pol,
	output logic [7:0]      kbd_data,
	output logic            kbd_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic act = 1'b0;
	// Strobe follows polarity so a polarity swap never looks like a key
	assign kbd_strobe = act ^ pol;
	initial kbd_data = 8'h00;
	task automatic press(input logic [7:0] d, input bit pulse);
		@(posedge clk);
		#1 kbd_data = d;
		act = 1'b1;
		if (pulse) begin
			@(posedge clk);
			#1 let_go();
		end
	endtask : press
	task automatic let_go();
		act = 1'b0;
		kbd_data = ~kbd_data;
	endtask : let_go
endmodule : kbd_model
`default_nettype wire

// ===== verif/tb_video_terminal_board.sv
// Purpose: Self-checking bench for the bus face of the video terminal
// Assumes: Bus strobes are one-cycle pulses, inputs change 1 ns after clk rises
// Notes:   Scan fetch and blanking are checked against a full-memory model
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin n_mismatch++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_video_terminal_board;
	timeunit 1ns;
	timeprecision 1ps;
	import vt_pkg::*;
	logic              clk = 0, nrst = 0, mem_rd = 0, mem_wr = 0, io_rd = 0;
	logic              half_k = 0, lls = 0, cds = 0, pol = 0;
	logic [ADDR_W-1:0] addr = 16'h0000;
	logic [DATA_W-1:0] wdata = 8'h00, rdata, code, kdata;
	logic [BASE_W-1:0] base = 6'h22;
	logic [PORT_W-1:0] port = 7'h44;
	logic [COL_W-1:0]  col, c0;
	logic [ROW_W-1:0]  row, r0;
	logic [DATA_W-1:0] vm [MEM_WORDS];
	logic              drv, irq, blank, kstb;
	int                n_mismatch = 0, n_checks = 0, exp_lat, exp_irq, n;
	int                mem_m[int];
	logic [5:0]        bases[3] = '{6'h22, 6'h3e, 6'h00};
	always #20 clk = ~clk;
	kbd_model kbd (.clk(clk), .pol(pol), .kbd_data(kdata), .kbd_strobe(kstb));
	video_terminal_board DUT (.clk(clk), .nrst(nrst), .bus_addr(addr), .bus_wdata(wdata),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .io_rd(io_rd), .base_select(base),
		.half_k_select(half_k), .port_select(port), .line_length_select(lls),
		.clock_divide_select(cds), .strobe_polarity_select(pol), .kbd_data(kdata),
		.kbd_strobe(kstb), .bus_rdata_q(rdata), .bus_drive_q(drv), .irq_q(irq),
		.char_code_q(code), .char_blank_q(blank), .col_q(col), .row_q(row));
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic req(input int k, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 addr = a;
		wdata = d;
		{mem_rd, mem_wr, io_rd} = {k == 0, k == 1, k == 2};
		@(posedge clk);
		#1 {mem_rd, mem_wr, io_rd} = 3'h0;
	endtask : req
	task automatic rd_chk(input int k, input logic [15:0] a, input logic ed,
		input logic [7:0] ev);
		req(k, a, 8'h00);
		`CHK("drive", ed, drv)
		`CHK("rdata", ev, rdata)
	endtask : rd_chk
	task automatic next_col(output int k);
		logic [COL_W-1:0] c;
		c = col;
		k = 0;
		while (col === c && k < 20) begin
			@(posedge clk);
			#1 k++;
		end
	endtask : next_col
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	initial begin
		#2000000 n_mismatch++;
		complete_run();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(86));
		repeat (12) @(posedge clk);
		#1 nrst = 1;
		for (int p = 0; p < 4; p++) begin
			pol = p[1];
			exp_lat = $urandom & 8'hff;
			kbd.press(exp_lat[7:0], p[0]);
			exp_irq = 1;
			repeat (3) @(posedge clk);
			#1 `CHK("irq", exp_irq[0], irq)
			rd_chk(2, {8'h00, port, 1'b1}, 1, {kstb, 6'h00, exp_irq[0]});
			rd_chk(2, {8'h00, port, 1'b0}, 1, exp_lat[7:0]);
			exp_irq = 0;
			repeat (4) @(posedge clk);
			rd_chk(2, {8'h00, port, 1'b1}, 1, {kstb, 6'h00, exp_irq[0]});
			`CHK("irq", exp_irq[0], irq)
			if (!p[0]) kbd.let_go();
		end
		// Keypress lands in the same cycle as a data read: the set must win
		n = $urandom & 8'hff;
		fork
			kbd.press(8'(n), 1'b1);
			rd_chk(2, {8'h00, port, 1'b0}, 1, exp_lat[7:0]);
		join
		`CHK("irq", 1'b1, irq)
		rd_chk(2, {8'h00, port, 1'b0}, 1, 8'(n));
		rd_chk(2, {8'h00, port ^ 7'h01, 1'b0}, 0, 8'h00);
		for (int i = 0; i < 6; i++) begin
			base = bases[i % 3];
			half_k = i[0];
			n = {base, 10'($urandom & (half_k ? 10'h1ff : 10'h3ff))};
			mem_m[n] = $urandom & 8'hff;
			req(1, 16'(n), 8'(mem_m[n]));
			rd_chk(0, 16'(n), 1, 8'(mem_m[n]));
			rd_chk(0, 16'(n) ^ 16'h0400, 0, 8'h00);
			if (half_k) rd_chk(0, 16'(n) | 16'h0200, 0, 8'h00);
		end
		base = 6'h22;
		half_k = 1'b0;
		for (int a = 0; a < MEM_WORDS; a++) begin
			vm[a] = 8'($urandom);
			req(1, {base, 10'(a)}, vm[a]);
		end
		for (int s = 0; s < 2; s++) begin
			{cds, lls, half_k} = {3{s[0]}};
			repeat (10) @(posedge clk);
			#1 next_col(n);
			for (int j = 0; j < 70; j++) begin
				c0 = col;
				r0 = row;
				next_col(n);
				`CHK("ratio", int'(s ? DIV_RATIO_OTHER : DIV_RATIO_NATIVE), n)
				`CHK("col", c0 + 6'h1, col)
				`CHK("row", (c0 == COL_LAST) ? r0 + 4'h1 : r0, row)
				`CHK("code", vm[{half_k ? {1'b0, r0[2:0]} : r0, c0}], code)
				`CHK("blank", lls && (c0 >= 6'(NARROW_COLS)), blank)
			end
		end
		// Mid-run reset: outputs return to idle and the latch empties
		nrst = 0;
		#1 `CHK("reset", {3'b001, 10'h000, RESET_BYTE}, {irq, drv, blank, col, row, code})
		@(posedge clk);
		#1 nrst = 1;
		rd_chk(2, {8'h00, port, 1'b0}, 1, RESET_BYTE);
		complete_run();
	end
endmodule : tb_video_terminal_board
`default_nettype wire
